// ---- hw/hsf_pkg.sv ----
// Constants for the hardware monitor special function register bank
package hsf_pkg;

  localparam logic [7:0] HSF_TEST_VALUE_OFS  = 8'h4C;
  localparam logic [7:0] HSF_SPECIAL_CFG_OFS = 8'h4F;
  localparam logic [7:0] HSF_TEST_MODE_OFS   = 8'h4A;
  localparam logic [7:0] HSF_TEST_VALUE_RST  = 8'h00;
  localparam logic [7:0] HSF_SPECIAL_CFG_RST = 8'h00;
  localparam logic [7:0] HSF_TEST_MODE_RST   = 8'h00;
  localparam logic [7:0] HSF_UNMAPPED_RD     = 8'h00;
  localparam logic [7:0] HSF_RDATA_RST       = 8'h00;

  localparam int HSF_LOWPWR_BIT   = 0;
  localparam int HSF_MONMODE_BIT  = 1;
  localparam int HSF_ALARM_EN_BIT = 2;
  localparam int HSF_VOLT_EN_BIT  = 3;
  localparam int HSF_OFS_INT_BIT  = 4;
  localparam int HSF_FASTAVG_BIT  = 5;
  localparam int HSF_CFG_MSB      = 5;
  localparam int HSF_DTEST_BIT    = 1;

  localparam logic [7:0] HSF_AVG_REMOTE_SLOW = 8'h80;
  localparam logic [7:0] HSF_AVG_OTHER_SLOW  = 8'h08;
  localparam logic [7:0] HSF_AVG_REMOTE_FAST = 8'h10;
  localparam logic [7:0] HSF_AVG_OTHER_FAST  = 8'h01;

endpackage : hsf_pkg

// ---- hw/hsf_regs.sv ----
// Special function and test digital value registers of the hardware monitor
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps

module hsf_regs
  import hsf_pkg::*;
(
  input  wire logic       i_clk,                // 50 MHz system clock
  input  wire logic       i_rst,                // Async reset, monitor supply POR
  input  wire logic       i_init,               // Initialization request, sync
  input  wire logic [7:0] i_addr,               // Register offset
  input  wire logic       i_wr,                 // Write strobe
  input  wire logic [7:0] i_wdata,              // Write data
  input  wire logic       i_rd,                 // Read strobe
  input  wire logic       i_round_start,        // Measurement round boundary pulse
  input  wire logic       i_temp_limit_hit,     // Temperature at/over limit
  input  wire logic       i_volt_limit_hit,     // Voltage at/over limit
  input  wire logic       i_alt_function_sel,   // Voltage-id bit 7 alternate select
  output logic [7:0]      o_rdata,              // Read data, registered
  output logic            o_shutdown_sel,       // 1 shutdown, 0 sleep
  output logic            o_cycle_monitor,      // 1 cycle, 0 continuous
  output logic            o_alarm_pin_en,       // Pin carries thermal alarm
  output logic            o_alt_function_sel,   // Alternate function select to pin mux
  output logic            o_thermal_alarm_n,    // Thermal alarm, active low
  output logic            o_offset_internal,    // Offset applies to internal channel
  output logic [7:0]      o_avg_remote,         // Remote diode sample count
  output logic [7:0]      o_avg_other,          // Voltage/internal sample count
  output logic            o_digital_test,       // Digital test mode active
  output logic [7:0]      o_test_value          // Value used in digital test mode
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [HSF_CFG_MSB:0] cfg_reg;
  logic [HSF_CFG_MSB:0] cfg_next;
  logic [7:0]           test_value_reg;
  logic [7:0]           test_value_next;
  logic [7:0]           test_mode_reg;
  logic [7:0]           test_mode_next;
  logic                 cycle_mon_reg;
  logic                 cycle_mon_next;
  logic                 fast_avg_reg;
  logic                 fast_avg_next;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire sel_cfg   = (i_addr == HSF_SPECIAL_CFG_OFS);
  wire sel_tval  = (i_addr == HSF_TEST_VALUE_OFS);
  wire sel_tmode = (i_addr == HSF_TEST_MODE_OFS);
  // Unmapped offsets match none of these, so writes there are dropped
  wire wr_cfg    = i_wr && sel_cfg;
  wire wr_tval   = i_wr && sel_tval;
  wire wr_tmode  = i_wr && sel_tmode;

  // ------------------------------------------------------------
  // Next register values
  // ------------------------------------------------------------
  // Initialization outranks a write landing in the same cycle
  assign cfg_next        = i_init ? HSF_SPECIAL_CFG_RST[HSF_CFG_MSB:0] :
                           wr_cfg ? i_wdata[HSF_CFG_MSB:0] : cfg_reg;
  assign test_value_next = i_init ? HSF_TEST_VALUE_RST :
                           wr_tval ? i_wdata : test_value_reg;
  assign test_mode_next  = i_init ? HSF_TEST_MODE_RST :
                           wr_tmode ? i_wdata : test_mode_reg;

  // ------------------------------------------------------------
  // Mode bits latched at round boundaries
  // ------------------------------------------------------------
  // A conversion in flight keeps its settings; new ones wait for the round edge
  assign cycle_mon_next = i_init        ? HSF_SPECIAL_CFG_RST[HSF_MONMODE_BIT] :
                          i_round_start ? cfg_reg[HSF_MONMODE_BIT] : cycle_mon_reg;
  assign fast_avg_next  = i_init        ? HSF_SPECIAL_CFG_RST[HSF_FASTAVG_BIT] :
                          i_round_start ? cfg_reg[HSF_FASTAVG_BIT] : fast_avg_reg;

  // ------------------------------------------------------------
  // Register flops
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cfg_reg <= HSF_SPECIAL_CFG_RST[HSF_CFG_MSB:0];
    end
    else
    begin
      cfg_reg <= cfg_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      test_value_reg <= HSF_TEST_VALUE_RST;
    end
    else
    begin
      test_value_reg <= test_value_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      test_mode_reg <= HSF_TEST_MODE_RST;
    end
    else
    begin
      test_mode_reg <= test_mode_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cycle_mon_reg <= HSF_SPECIAL_CFG_RST[HSF_MONMODE_BIT];
    end
    else
    begin
      cycle_mon_reg <= cycle_mon_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      fast_avg_reg <= HSF_SPECIAL_CFG_RST[HSF_FASTAVG_BIT];
    end
    else
    begin
      fast_avg_reg <= fast_avg_next;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Bits 7:6 are not stored, so they read back as zero
  wire [7:0] cfg_read   = {2'b00, cfg_reg};
  wire [7:0] rd_mux     = sel_cfg   ? cfg_read :
                          sel_tval  ? test_value_reg :
                          sel_tmode ? test_mode_reg :
                          HSF_UNMAPPED_RD;
  // Read data holds between reads, so a slow host may fetch it late
  wire [7:0] rdata_next = i_rd ? rd_mux : o_rdata;

  // ------------------------------------------------------------
  // Thermal alarm
  // ------------------------------------------------------------
  wire volt_cause           = cfg_reg[HSF_VOLT_EN_BIT] && i_volt_limit_hit;
  wire alarm_cause          = i_temp_limit_hit || volt_cause;
  // Alarm only driven when the pin is in alarm mode
  wire thermal_alarm_n_next = ~(cfg_reg[HSF_ALARM_EN_BIT] && alarm_cause);

  // ------------------------------------------------------------
  // Averaging counts
  // ------------------------------------------------------------
  wire [7:0] avg_remote_next = fast_avg_reg ? HSF_AVG_REMOTE_FAST : HSF_AVG_REMOTE_SLOW;
  wire [7:0] avg_other_next  = fast_avg_reg ? HSF_AVG_OTHER_FAST : HSF_AVG_OTHER_SLOW;

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  // Each output has its own flop so the pins never see decode glitches
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= HSF_RDATA_RST;
    end
    else
    begin
      o_rdata <= rdata_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_shutdown_sel <= HSF_SPECIAL_CFG_RST[HSF_LOWPWR_BIT];
    end
    else
    begin
      o_shutdown_sel <= cfg_reg[HSF_LOWPWR_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_cycle_monitor <= HSF_SPECIAL_CFG_RST[HSF_MONMODE_BIT];
    end
    else
    begin
      o_cycle_monitor <= cycle_mon_reg;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_alarm_pin_en <= HSF_SPECIAL_CFG_RST[HSF_ALARM_EN_BIT];
    end
    else
    begin
      o_alarm_pin_en <= cfg_reg[HSF_ALARM_EN_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_alt_function_sel <= 1'b0;
    end
    else
    begin
      o_alt_function_sel <= i_alt_function_sel;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_thermal_alarm_n <= 1'b1;
    end
    else
    begin
      o_thermal_alarm_n <= thermal_alarm_n_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_offset_internal <= HSF_SPECIAL_CFG_RST[HSF_OFS_INT_BIT];
    end
    else
    begin
      o_offset_internal <= cfg_reg[HSF_OFS_INT_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_avg_remote <= HSF_AVG_REMOTE_SLOW;
    end
    else
    begin
      o_avg_remote <= avg_remote_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_avg_other <= HSF_AVG_OTHER_SLOW;
    end
    else
    begin
      o_avg_other <= avg_other_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_digital_test <= HSF_TEST_MODE_RST[HSF_DTEST_BIT];
    end
    else
    begin
      o_digital_test <= test_mode_reg[HSF_DTEST_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_test_value <= HSF_TEST_VALUE_RST;
    end
    else
    begin
      o_test_value <= test_value_reg;
    end
  end

endmodule : hsf_regs

// ---- tb/hsf_regs_sva.sv ----
// Checker for the special function register bank
`timescale 1ns/1ps
module hsf_regs_sva
  import hsf_pkg::*;
(
  input wire logic       i_clk,              // Clock
  input wire logic       i_rst,              // Async reset
  input wire logic       i_init,             // Initialization request
  input wire logic       i_wr,               // Write strobe
  input wire logic       i_rd,               // Read strobe
  input wire logic       i_round_start,      // Round boundary pulse
  input wire logic       i_temp_limit_hit,   // Temperature at limit
  input wire logic       i_alt_function_sel, // Alternate select in
  input wire logic [7:0] i_addr,             // Register offset
  input wire logic [7:0] i_wdata,            // Write data
  input wire logic [7:0] o_rdata,            // Read data
  input wire logic [7:0] o_avg_remote,       // Remote sample count
  input wire logic [7:0] o_avg_other,        // Other sample count
  input wire logic [7:0] o_test_value,       // Test value out
  input wire logic       o_shutdown_sel,     // Low power select
  input wire logic       o_cycle_monitor,    // Monitor mode
  input wire logic       o_alarm_pin_en,     // Pin in alarm mode
  input wire logic       o_alt_function_sel, // Alternate select out
  input wire logic       o_thermal_alarm_n,  // Alarm, active low
  input wire logic       o_offset_internal,  // Offset routing
  input wire logic       o_digital_test      // Digital test active
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire cfg_wr = i_wr && i_addr == HSF_SPECIAL_CFG_OFS && !i_init;
  wire tv_wr  = i_wr && i_addr == HSF_TEST_VALUE_OFS && !i_init;
  wire tm_wr  = i_wr && i_addr == HSF_TEST_MODE_OFS && !i_init;
  logic [7:0] wd1, wd2;
  always_ff @(posedge i_clk)
  begin
    wd1 <= i_wdata;
    wd2 <= wd1;
  end
  a_lowpwr_follows: assert property (cfg_wr |-> ##2 o_shutdown_sel == wd2[0]) else $error("low power select");
  a_pin_select: assert property (cfg_wr |-> ##2 o_alarm_pin_en == wd2[2]) else $error("pin select");
  a_offset_route: assert property (cfg_wr |-> ##2 o_offset_internal == wd2[4]) else $error("offset route");
  a_test_follows: assert property (tv_wr |-> ##2 o_test_value == wd2) else $error("test value");
  a_rd_reserved: assert property (i_rd && i_addr == HSF_SPECIAL_CFG_OFS |=> o_rdata[7:6] == 2'b00)
    else $error("reserved bits");
  a_temp_alarm: assert property (o_alarm_pin_en && $past(i_temp_limit_hit) |-> !o_thermal_alarm_n)
    else $error("alarm missing");
  a_pin_off_idle: assert property (!o_alarm_pin_en |-> o_thermal_alarm_n) else $error("alarm while off");
  a_avg_pairs: assert property (
    (o_avg_remote == HSF_AVG_REMOTE_SLOW && o_avg_other == HSF_AVG_OTHER_SLOW) ||
    (o_avg_remote == HSF_AVG_REMOTE_FAST && o_avg_other == HSF_AVG_OTHER_FAST)) else $error("average counts");
  a_mode_at_round: assert property (($changed(o_cycle_monitor) || $changed(o_avg_remote)) |->
    $past(i_round_start, 2) || $past(i_init, 2) || $past(i_init)) else $error("mode outside round");
  a_init_clears: assert property (i_init |-> ##2
    !o_shutdown_sel && !o_alarm_pin_en && o_test_value == HSF_TEST_VALUE_RST) else $error("init clear");
  a_dtest_follows: assert property (tm_wr |-> ##2 o_digital_test == wd2[HSF_DTEST_BIT]) else $error("digital test");
  a_alt_follows: assert property (!$past(i_rst) |-> o_alt_function_sel == $past(i_alt_function_sel))
    else $error("alternate select");
endmodule : hsf_regs_sva
bind hsf_regs hsf_regs_sva hsf_regs_sva_i (.*);

// ---- tb/hsf_host.sv ----
// Host side model that makes register transfers
`timescale 1ns/1ps
module hsf_host (
  input  wire logic       i_clk,   // System clock
  input  wire logic [7:0] i_rdata, // Read data
  output logic            o_wr,    // Write strobe
  output logic            o_rd,    // Read strobe
  output logic [7:0]      o_addr,  // Offset
  output logic [7:0]      o_wdata  // Write data
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0_0000;
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge i_clk);
    {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
    @(negedge i_clk);
    // Released address and data lines flip so a stale value is never mistaken for a driven one
    {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
    q = i_rdata;
  endtask : xfer
endmodule : hsf_host

// ---- tb/test_hsf_regs.sv ----
// Self-checking testbench of the special function register bank
`timescale 1ns/1ps
module test_hsf_regs
  import hsf_pkg::*;
;
  logic i_clk = 0, i_rst = 1, i_init = 0, i_wr, i_rd, i_round_start = 0;
  logic i_temp_limit_hit = 0, i_volt_limit_hit = 0, i_alt_function_sel = 0;
  logic [7:0] i_addr, i_wdata, o_rdata, o_avg_remote, o_avg_other, o_test_value, q;
  logic o_shutdown_sel, o_cycle_monitor, o_alarm_pin_en, o_alt_function_sel, o_thermal_alarm_n;
  logic o_offset_internal, o_digital_test;
  int failures = 0, tests_run = 0;
  hsf_regs hsf_regs_i (.*);
  hsf_host hsf_host_i (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
  task automatic chk(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    hsf_host_i.xfer(1'b1, a, d, q);
    repeat (2) @(negedge i_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, exp);
    hsf_host_i.xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rd
  task automatic pulse(ref logic s);
    @(negedge i_clk) s = 1;
    @(negedge i_clk) s = 0;
    repeat (2) @(negedge i_clk);
  endtask : pulse
  task automatic t_cfg();
    rd(HSF_SPECIAL_CFG_OFS, 8'h00);
    wr(HSF_SPECIAL_CFG_OFS, 8'hFF);
    rd(HSF_SPECIAL_CFG_OFS, 8'h3F);
    chk({o_offset_internal, o_alarm_pin_en, o_shutdown_sel, o_cycle_monitor, o_avg_remote[7:4]}, 8'hE8);
    pulse(i_round_start);
    chk({o_cycle_monitor, o_avg_other[6:0]}, 8'h81);
    chk(o_avg_remote, 8'h10);
    wr(HSF_SPECIAL_CFG_OFS, 8'h00);
    pulse(i_round_start);
    chk({o_avg_remote[7:4], o_avg_other[3:0]}, 8'h88);
  endtask : t_cfg
  task automatic t_alarm();
    wr(HSF_SPECIAL_CFG_OFS, 8'h04);
    i_volt_limit_hit = 1;
    i_alt_function_sel = 1;
    repeat (2) @(negedge i_clk);
    chk({6'h00, o_thermal_alarm_n, o_alt_function_sel}, 8'h03);
    wr(HSF_SPECIAL_CFG_OFS, 8'h0C);
    chk({6'h00, o_thermal_alarm_n, o_alarm_pin_en}, 8'h01);
    i_volt_limit_hit = 0;
    i_temp_limit_hit = 1;
    wr(HSF_SPECIAL_CFG_OFS, 8'h00);
    chk({6'h00, o_thermal_alarm_n, o_alarm_pin_en}, 8'h02);
    i_temp_limit_hit = 0;
  endtask : t_alarm
  task automatic t_test();
    rd(HSF_TEST_VALUE_OFS, 8'h00);
    wr(HSF_TEST_VALUE_OFS, 8'hA5);
    rd(HSF_TEST_VALUE_OFS, 8'hA5);
    chk({o_digital_test, o_test_value[6:0]}, 8'h25);
    wr(8'h4E, 8'hFF);
    rd(HSF_TEST_VALUE_OFS, 8'hA5);
    wr(HSF_TEST_MODE_OFS, 8'h02);
    chk({7'h00, o_digital_test}, 8'h01);
    rd(8'h50, 8'h00);
    wr(HSF_SPECIAL_CFG_OFS, 8'h01);
    pulse(i_init);
    rd(HSF_SPECIAL_CFG_OFS, 8'h00);
    chk({o_digital_test, o_test_value[6:0]}, 8'h00);
  endtask : t_test
  task automatic stop_test();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  initial forever #10 i_clk = ~i_clk;
  initial
  begin
    repeat (5) @(negedge i_clk);
    i_rst = 0;
    t_cfg();
    t_alarm();
    t_test();
    stop_test();
  end
  initial
  begin
    #100us;
    failures++;
    stop_test();
  end
endmodule : test_hsf_regs
